// file: hdl/dct_pkg.sv
package dct_pkg;
  // Internal frequency divided by this gives the timed prescaler source
  localparam int unsigned INTERNAL_FREQUENCY_DIV      = 12;
  localparam logic [3:0]  INTERNAL_FREQUENCY_DIV_LAST = 4'(INTERNAL_FREQUENCY_DIV - 1);

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_PSC  = 8'hd2;
  localparam logic [7:0]  IDX_CNT  = 8'hd3;
  localparam logic [7:0]  IDX_CSR  = 8'hd4;
  localparam logic [11:0] ADDR_PSC = {2'h0, IDX_PSC, 2'h0};
  localparam logic [11:0] ADDR_CNT = {2'h0, IDX_CNT, 2'h0};
  localparam logic [11:0] ADDR_CSR = {2'h0, IDX_CSR, 2'h0};

  // Control/status field positions
  localparam int unsigned ZF_BIT  = 7;
  localparam int unsigned IE_BIT  = 6;
  localparam int unsigned DIR_BIT = 5;
  localparam int unsigned LVL_BIT = 4;
  localparam int unsigned RUN_BIT = 3;
  localparam int unsigned TAP_LSB = 0;
  localparam int unsigned TAP_MSB = 2;

  // Values after reset
  localparam logic [7:0]  CNT_RST = 8'hff;
  localparam logic [6:0]  PSC_RST = 7'h7f;
  localparam logic [7:0]  CSR_RST = 8'h00;

  // AXI4-Lite answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Pin modes, one-hot
  typedef enum logic [2:0] {
    MODE_EVENT  = 3'b001,
    MODE_GATED  = 3'b010,
    MODE_OUTPUT = 3'b100
  } dct_mode_type;

  // Mode from pin direction and pin level bits
  function automatic dct_mode_type dct_mode_of(input logic dir, input logic lvl);
    if (dir)
      dct_mode_of = MODE_OUTPUT;
    else if (lvl)
      dct_mode_of = MODE_GATED;
    else
      dct_mode_of = MODE_EVENT;
  endfunction : dct_mode_of
endpackage : dct_pkg

// file: hdl/dct_clk_src.sv
`timescale 1ns/1ps
module dct_clk_src
  import dct_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire dct_mode_type mode,
  input  wire logic         pin_i,
  output logic              src_tick
);
  typedef struct packed {
    logic [3:0] div;    // Divide-by-12 phase
    logic       pin_d;  // Pin level one clock ago
  } dct_src_state_type;

  dct_src_state_type s_r;       // Registered state
  dct_src_state_type s_nxt;     // Next state
  logic              div_tick;  // Internal frequency / 12 strobe

  // Divider, pin edge and source select
  always_comb
  begin
    s_nxt       = s_r;
    div_tick    = (s_r.div == INTERNAL_FREQUENCY_DIV_LAST);
    s_nxt.div   = div_tick ? 4'h0 : 4'(s_r.div + 4'h1);
    s_nxt.pin_d = pin_i;
    unique case (mode)
      MODE_EVENT:  src_tick = pin_i & ~s_r.pin_d;  // RQ10
      MODE_GATED:  src_tick = div_tick & pin_i;    // RQ9
      MODE_OUTPUT: src_tick = div_tick;            // RQ11
      default:     src_tick = 1'b0;                // Illegal code: no tick
    endcase
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= '{div: 4'h0, pin_d: 1'b1};  // Pin seen high: a pin idling high gives no false edge
    else
      s_r <= s_nxt;
  end

  property p_div_period;
    @(posedge aclk) disable iff (!aresetn) div_tick |-> ##12 div_tick;
  endproperty
  a_div_period: assert property (p_div_period) else $error("div12 period wrong"); // RQ4
endmodule : dct_clk_src

// file: hdl/dct_prescaler.sv
`timescale 1ns/1ps
module dct_prescaler
  import dct_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       load,
  input  wire logic [6:0] load_val,
  input  wire logic       tick,
  input  wire logic [2:0] tap,
  output logic [6:0]      value,
  output logic            cnt_tick
);
  typedef struct packed {
    logic [6:0] prescaler_register;  // Prescaler count
  } dct_psc_state_type;

  dct_psc_state_type s_r;    // Registered state
  dct_psc_state_type s_nxt;  // Next state
  logic [6:0]        dec;    // Prescaler minus one

  // Down count, forced load and tap edge
  always_comb
  begin
    s_nxt    = s_r;
    dec      = 7'(s_r.prescaler_register - 7'h01);
    cnt_tick = 1'b0;
    if (!run)
      s_nxt.prescaler_register = PSC_RST;  // RQ6
    else if (load)
      s_nxt.prescaler_register = load_val;  // RQ7
    else if (tick)
    begin
      s_nxt.prescaler_register = dec;  // RQ4
      // Tap bit rising on the borrow is the counter clock edge
      if (tap == 3'h0)
        cnt_tick = 1'b1;  // RQ5
      else
        cnt_tick = ~s_r.prescaler_register[tap - 3'h1] & dec[tap - 3'h1];  // RQ5 RQ19
    end
  end

  assign value = s_r.prescaler_register;

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r.prescaler_register <= PSC_RST;
    else
      s_r <= s_nxt;
  end

  property p_stopped;
    @(posedge aclk) disable iff (!aresetn) !run |=> value == PSC_RST;
  endproperty
  a_stopped: assert property (p_stopped) else $error("prescaler not forced"); // RQ6
endmodule : dct_prescaler

// file: hdl/dct_timer.sv
// Overview of operation
// RQ1: Eight-bit counter decrements on selected prescaler edge.
// RQ2: Reaching zero sets the zero flag.
// RQ3: Zero flag with enable raises wake-capable request.
// RQ4: Prescaler source: internal frequency/12 or pin.
// RQ5: Tap picks prescaler input or prescaler bit.
// RQ6: Run low forces prescaler ones, stops counter.
// RQ7: Running prescaler loadable with 0 to 7Fh.
// RQ8: Direction and level bits pick the mode.
// RQ9: Gated mode counts internal ticks while pin high.
// RQ10: Event mode counts pin rising edges.
// RQ11: Output mode: internal ticks, pin from latch.
// RQ12: Pin latch transparent while zero flag high.
// RQ13: Writing 00h count or bit7 sets flag.
// RQ14: Software clears zero flag when servicing.
// RQ15: Reset: count FFh, prescaler 7Fh, control cleared.
// RQ16: Count write beats simultaneous decrement to zero.
// RQ17: Count and prescaler readable live anytime.
// RQ18: Control layout: flag, enable, dir, level, run, tap.
// RQ19: Tap codes give divide 1 through 128.
// RQ20: Prescaler bit 7 always reads zero.
// RQ21: Counter wraps 00h to FFh and continues.
// RQ22: Flag set on the zero edge, sticky.
`timescale 1ns/1ps
module dct_timer
  import dct_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        timer_pin_i,
  output logic             timer_pin_o,
  output logic             timer_pin_oe_n,
  output logic             timer_irq
);
  typedef struct packed {
    logic        aw_full;  // Write address held
    logic [11:0] aw_addr;  // Held write address
    logic        w_full;   // Write data held
    logic [7:0]  w_data;   // Held write data, low byte
    logic        w_lane0;  // Low byte lane enabled
    logic        bvalid;   // Write answer pending
    logic [1:0]  bresp;    // Write answer code
    logic        rvalid;   // Read answer pending
    logic [7:0]  rdata;    // Read answer data
    logic [1:0]  rresp;    // Read answer code
    logic [7:0]  cnt;      // Count register
    logic [7:0]  csr;      // Timer control/status
    logic        pin_out;  // Output pin latch
  } dct_top_state_type;

  dct_top_state_type s_r;       // Registered state
  dct_top_state_type s_nxt;     // Next state
  dct_mode_type      mode;      // Decoded pin mode
  logic [2:0]        wsel;      // Write target, one-hot
  logic [2:0]        rsel;      // Read target, one-hot
  logic              wr_go;     // Commit held write
  logic              wr_psc;    // Write hits prescaler
  logic              wr_cnt;    // Write hits count
  logic              wr_csr;    // Write hits control
  logic              psc_load;  // Prescaler load while running
  logic              hit_zero;  // Decrement lands on zero
  logic              zf_set;    // Any cause setting the flag
  logic              src_tick;  // Prescaler source strobe
  logic              cnt_tick;  // Counter clock strobe
  logic [6:0]        psc_val;   // Live prescaler value

  // Register decode; the unused protection bits have no effect here
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    reg_sel = {a == ADDR_CSR, a == ADDR_CNT, a == ADDR_PSC};
  endfunction : reg_sel

  // Prescaler source: divider, gate or pin edge
  dct_clk_src u_src (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .mode     (mode),
    .pin_i    (timer_pin_i),
    .src_tick (src_tick)
  );

  // Seven-bit prescaler with tap select
  dct_prescaler u_psc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (s_r.csr[RUN_BIT]),
    .load     (psc_load),
    .load_val (s_r.w_data[6:0]),
    .tick     (src_tick),
    .tap      (s_r.csr[TAP_MSB:TAP_LSB]),
    .value    (psc_val),
    .cnt_tick (cnt_tick)
  );

  // Bus handshakes and timer next state
  always_comb
  begin
    s_nxt = s_r;
    mode  = dct_mode_of(s_r.csr[DIR_BIT], s_r.csr[LVL_BIT]);  // RQ8

    // Address and data are taken in either order and held until commit
    if (awvalid && awready)
    begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.w_full  = 1'b1;
      s_nxt.w_data  = wdata[7:0];
      s_nxt.w_lane0 = wstrb[0];
    end

    // Commit once both are held and no answer is waiting
    wr_go  = s_r.aw_full & s_r.w_full & ~s_r.bvalid;
    wsel   = reg_sel(s_r.aw_addr);
    wr_psc = wr_go & s_r.w_lane0 & wsel[0];
    wr_cnt = wr_go & s_r.w_lane0 & wsel[1];
    wr_csr = wr_go & s_r.w_lane0 & wsel[2];
    // A load while stopped is dropped: the prescaler is held at ones
    psc_load = wr_psc & s_r.csr[RUN_BIT];  // RQ7
    if (wr_go)
    begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = (wsel != 3'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_r.bvalid && bready)
      s_nxt.bvalid = 1'b0;

    // Read: sample the live registers at the address handshake
    rsel = reg_sel(araddr);
    if (arvalid && arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = (rsel != 3'h0) ? RESP_OKAY : RESP_SLVERR;
      unique case (1'b1)
        rsel[0]: s_nxt.rdata = {1'b0, psc_val};  // RQ17 RQ20
        rsel[1]: s_nxt.rdata = s_r.cnt;          // RQ17
        rsel[2]: s_nxt.rdata = s_r.csr;          // RQ18
        default: s_nxt.rdata = 8'h00;            // Unmapped reads zero
      endcase
    end
    else if (s_r.rvalid && rready)
      s_nxt.rvalid = 1'b0;

    // Counter: a software write beats the decrement
    hit_zero = cnt_tick & ~wr_cnt & (s_r.cnt == 8'h01);  // RQ16 RQ22
    if (wr_cnt)
      s_nxt.cnt = s_r.w_data;  // RQ16
    else if (cnt_tick)
      s_nxt.cnt = 8'(s_r.cnt - 8'h01);  // RQ1 RQ21

    // Zero flag: any set cause wins over a clearing write
    zf_set = hit_zero | (wr_cnt & (s_r.w_data == 8'h00))
           | (wr_csr & s_r.w_data[ZF_BIT]);  // RQ2 RQ13
    if (wr_csr)
      s_nxt.csr = s_r.w_data;  // RQ18
    if (zf_set)
      s_nxt.csr[ZF_BIT] = 1'b1;  // RQ22

    // Pin latch follows the level bit while the flag is high
    if (s_nxt.csr[ZF_BIT])
      s_nxt.pin_out = s_nxt.csr[LVL_BIT];  // RQ12
  end

  // Handshake outputs
  assign awready = ~s_r.aw_full;
  assign wready  = ~s_r.w_full;
  assign arready = ~s_r.rvalid;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign rvalid  = s_r.rvalid;
  assign rresp   = s_r.rresp;
  assign rdata   = {24'h000000, s_r.rdata};

  // Pin drive only in output mode; enable is active low
  assign timer_pin_o    = s_r.pin_out;  // RQ11
  assign timer_pin_oe_n = ~s_r.csr[DIR_BIT];  // RQ8
  // Level request, needs no clock edge to wake the core
  assign timer_irq = s_r.csr[ZF_BIT] & s_r.csr[IE_BIT];  // RQ3

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r     <= '0;
      s_r.cnt <= CNT_RST;  // RQ15
      s_r.csr <= CSR_RST;  // RQ15
    end
    else
      s_r <= s_nxt;
  end

  property p_dec;
    @(posedge aclk) disable iff (!aresetn)
      cnt_tick && !wr_cnt |=> s_r.cnt == 8'($past(s_r.cnt) - 8'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("count did not decrement"); // RQ1

  property p_zero_set;
    @(posedge aclk) disable iff (!aresetn)
      hit_zero |=> s_r.csr[ZF_BIT] && s_r.cnt == 8'h00;
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero flag not set"); // RQ2

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      hit_zero && s_r.csr[IE_BIT] && !wr_csr |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing at zero"); // RQ3

  property p_stopped;
    @(posedge aclk) disable iff (!aresetn)
      !s_r.csr[RUN_BIT] |-> !cnt_tick ##1 (psc_val == PSC_RST);
  endproperty
  a_stopped: assert property (p_stopped) else $error("timer ran while stopped"); // RQ6

  property p_psc_load;
    @(posedge aclk) disable iff (!aresetn)
      psc_load |=> psc_val == $past(s_r.w_data[6:0]);
  endproperty
  a_psc_load: assert property (p_psc_load) else $error("prescaler load lost"); // RQ7

  property p_latch_hold;
    @(posedge aclk) disable iff (!aresetn)
      !s_r.csr[ZF_BIT] ##1 !s_r.csr[ZF_BIT] |-> $stable(timer_pin_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("pin latch moved"); // RQ12

  property p_sw_zero;
    @(posedge aclk) disable iff (!aresetn)
      wr_cnt && s_r.w_data == 8'h00 |=> s_r.csr[ZF_BIT] && s_r.cnt == 8'h00;
  endproperty
  a_sw_zero: assert property (p_sw_zero) else $error("write 00h left flag low"); // RQ13

  property p_wr_wins;
    @(posedge aclk) disable iff (!aresetn)
      wr_cnt && cnt_tick |=> s_r.cnt == $past(s_r.w_data);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("decrement beat write"); // RQ16

  property p_psc_read;
    @(posedge aclk) disable iff (!aresetn)
      arvalid && arready && rsel[0] |=> rvalid && rdata[7] == 1'b0;
  endproperty
  a_psc_read: assert property (p_psc_read) else $error("prescaler bit 7 read set"); // RQ20

  // Reset loads the start values and leaves the timer stopped
  property p_reset_vals;
    @(posedge aclk)
      !aresetn |=> s_r.cnt == CNT_RST && s_r.csr == CSR_RST && psc_val == PSC_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // RQ15

  // Counter wraps through zero instead of stopping there
  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
      cnt_tick && !wr_cnt && s_r.cnt == 8'h00 |=> s_r.cnt == 8'hff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap"); // RQ21

  // Control write lands in every bit below the flag
  property p_csr_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_csr |=> s_r.csr[IE_BIT:TAP_LSB] == $past(s_r.w_data[IE_BIT:TAP_LSB]);
  endproperty
  a_csr_write: assert property (p_csr_write) else $error("control write lost"); // RQ18

  // Writing the flag bit high sets the flag
  property p_csr_set;
    @(posedge aclk) disable iff (!aresetn)
      wr_csr && s_r.w_data[ZF_BIT] |=> s_r.csr[ZF_BIT];
  endproperty
  a_csr_set: assert property (p_csr_set) else $error("flag write ignored"); // RQ13

  // Flag stays up until a control write clears it
  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
      s_r.csr[ZF_BIT] && !wr_csr |=> s_r.csr[ZF_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped by itself"); // RQ22

  // A nonzero count write never raises the flag, even on a zero decrement
  property p_no_false_zero;
    @(posedge aclk) disable iff (!aresetn)
      wr_cnt && s_r.w_data != 8'h00 && !s_r.csr[ZF_BIT] |=> !s_r.csr[ZF_BIT];
  endproperty
  a_no_false_zero: assert property (p_no_false_zero) else $error("flag set by write"); // RQ16

  // While the flag is high the pin latch shows the level bit
  property p_pin_follow;
    @(posedge aclk) disable iff (!aresetn)
      s_r.csr[ZF_BIT] |-> timer_pin_o == s_r.csr[LVL_BIT];
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin latch not open"); // RQ12

  // Gated mode gives no tick while the pin is low
  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
      mode == MODE_GATED && !timer_pin_i |-> !src_tick;
  endproperty
  a_gate: assert property (p_gate) else $error("gated tick with pin low"); // RQ9

  // Count read returns the value at the address handshake
  property p_cnt_read;
    @(posedge aclk) disable iff (!aresetn)
      arvalid && arready && rsel[1] |=> rdata[7:0] == $past(s_r.cnt);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count read wrong"); // RQ17

  // Event mode ticks only on a low-to-high pin change
  property p_event;
    @(posedge aclk) disable iff (!aresetn)
      mode == MODE_EVENT && src_tick |-> timer_pin_i && !$past(timer_pin_i);
  endproperty
  a_event: assert property (p_event) else $error("event tick without pin edge"); // RQ10

  // Each source tick takes one off a running prescaler unless a load lands in the same cycle
  property p_psc_dec;
    @(posedge aclk) disable iff (!aresetn)
      src_tick && s_r.csr[RUN_BIT] && !psc_load |=> psc_val == 7'($past(psc_val) - 7'h01);
  endproperty
  a_psc_dec: assert property (p_psc_dec) else $error("prescaler missed a tick"); // RQ4

  // Divide by one clocks the counter on every source tick while running and not loading the prescaler
  property p_tap1;
    @(posedge aclk) disable iff (!aresetn)
      s_r.csr[TAP_MSB:TAP_LSB] == 3'h0 && s_r.csr[RUN_BIT] && src_tick && !psc_load
        |-> cnt_tick;
  endproperty
  a_tap1: assert property (p_tap1) else $error("divide by one missed a tick"); // RQ5
endmodule : dct_timer

// file: test/dct_pin_src.sv
`timescale 1ns/1ps
// Far-side source on the timer pin
module dct_pin_src
(
  input  wire logic aclk,
  output logic      pin_drv
);
  // Idle low until a scenario asks for activity
  initial pin_drv = 1'b0;

  // One rising edge per pulse, one low cycle between them
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge aclk);
      pin_drv <= 1'b1;
      @(posedge aclk);
      pin_drv <= 1'b0;
    end
  endtask : pulse

  // Level held for n edges, then back to idle low
  task automatic hold(input logic lvl, input int n);
    @(posedge aclk);
    pin_drv <= lvl;
    repeat (n) @(posedge aclk);
    pin_drv <= 1'b0;
  endtask : hold
endmodule : dct_pin_src

// file: test/dct_timer_tb_top.sv
`timescale 1ns/1ps
// Bench: bus tasks, pin source and an integer timer model
module dct_timer_tb_top
  import dct_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pin_o, pin_oe_n, irq;
  logic        src_drv, pin_w;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          mismatches, num_checks, m_psc, m_cnt, m_tap, m_zf, m_csr;

  // Pin level: device wins while its enable is low
  assign pin_w = pin_oe_n ? src_drv : pin_o;

  dct_timer i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .timer_pin_i(pin_w), .timer_pin_o(pin_o),
    .timer_pin_oe_n(pin_oe_n), .timer_irq(irq));
  dct_pin_src i_src (.aclk(aclk), .pin_drv(src_drv));

  // 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // Counted compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // Bound on every handshake wait
  task automatic lim(inout int n);
    n++;
    if (n > 60)
    begin
      mismatches++;
      results();
    end
  endtask : lim

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      lim(n);
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
    r = bresp;
  endtask : axw

  // Read: address held until taken, rready held until the answer
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      lim(n);
    end
    while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axr

  // Mapped write expecting OKAY
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    axw(a, v, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask : wr

  // Model-tracking register writes
  task automatic set_csr(input logic [7:0] v);
    wr(ADDR_CSR, v);
    m_zf  = v[7];
    m_csr = v;
    m_tap = v[2:0];
    if (!v[3]) m_psc = 127;
  endtask : set_csr

  task automatic set_cnt(input logic [7:0] v);
    wr(ADDR_CNT, v);
    m_cnt = v;
    if (v == 8'h00) m_zf = 1;
  endtask : set_cnt

  task automatic set_psc(input logic [7:0] v);
    wr(ADDR_PSC, v);
    if (m_csr[3]) m_psc = v[6:0];
  endtask : set_psc

  // Read and compare value plus response
  task automatic rc(input logic [11:0] a, input int e);
    axr(a, rd, rs);
    chk({rd[29:0], rs}, {e[29:0], RESP_OKAY});
  endtask : rc

  // Prescaler, count, control and interrupt against the model
  task automatic cmp_all();
    rc(ADDR_PSC, m_psc);
    rc(ADDR_CNT, m_cnt);
    rc(ADDR_CSR, (m_zf << 7) | (m_csr & 127));
    chk({31'h0, irq}, {31'h0, m_zf[0] & m_csr[6]});
  endtask : cmp_all

  // Pin events: model first, then the real pulses
  task automatic ev(input int n);
    int nx;
    for (int i = 0; i < n; i++)
    begin
      nx = (m_psc - 1) & 127;
      if (m_tap == 0 || (!m_psc[m_tap-1] && nx[m_tap-1]))
      begin
        m_cnt = (m_cnt - 1) & 255;
        if (m_cnt == 0) m_zf = 1;
      end
      m_psc = nx;
    end
    i_src.pulse(n);
  endtask : ev

  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr  = 12'h000;
    araddr  = 12'h000;
    wdata   = 32'h0;
    wstrb   = 4'h1;
    {mismatches, num_checks, m_zf, m_csr, m_tap} = '0;
    m_psc = 127;
    m_cnt = 255;
    void'($urandom(62163));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    cmp_all();
    axw(12'h000, 8'h5a, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axr(12'h000, rd, rs);
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    // Stopped: prescaler write and pin edges have no effect
    set_psc(8'h11);
    i_src.pulse(5);
    cmp_all();
    // Event mode through every tap code
    for (int t = 0; t < 8; t++)
    begin
      set_csr(8'h08 | t[7:0]);
      set_psc(8'($urandom_range(127)));
      set_cnt(8'($urandom_range(255, 1)));
      ev(int'($urandom_range(40, 1)));
      cmp_all();
    end
    // Reaching zero, wrap, software clear, software set
    set_csr(8'h48);
    set_cnt(8'h02);
    ev(2);
    cmp_all();
    ev(1);
    cmp_all();
    set_csr(8'h48);
    cmp_all();
    set_cnt(8'h00);
    cmp_all();
    set_csr(8'hc8);
    cmp_all();
    // Count write committed on the same edge as the decrement to zero
    set_csr(8'h48);
    set_cnt(8'h01);
    fork
      set_cnt(8'h05);
      begin
        @(posedge aclk);
        i_src.pulse(1);
      end
    join
    m_psc = (m_psc - 1) & 127;
    cmp_all();
    // Gated: stop to force ones, start, then one step per 12 cycles of high pin
    set_csr(8'h17);
    rc(ADDR_PSC, 127);
    set_csr(8'h1f);
    i_src.hold(1'b1, 120);
    m_psc = 127 - 120 / INTERNAL_FREQUENCY_DIV;
    rc(ADDR_PSC, m_psc);
    // Output mode: pin follows level bit only while flag is high
    set_csr(8'h3f);
    set_cnt(8'h00);
    chk({30'h0, pin_oe_n, pin_o}, 32'h1);
    set_csr(8'h2f);
    chk({30'h0, pin_oe_n, pin_o}, 32'h1);
    set_csr(8'haf);
    chk({30'h0, pin_oe_n, pin_o}, 32'h0);
    results();
  end
endmodule : dct_timer_tb_top
